// File: logic/port_charge_limit_hit_flag_fault.sv
`timescale 1ns/1ps
`default_nettype none
module port_charge_limit_hit_flag_fault (
    input wire logic sys_clk, // system clock
    input wire logic rstn, // sync reset, low
    port_ctl_if.port p // per-port control bundle
);
    import charge_limit_hit_flag_pkg::*;

    pwr_state_e state_r, state_nxt;
    logic [1:0] beh_r, beh_nxt;
    logic hit_r, hit_nxt;
    logic alert_r, alert_nxt;
    logic err_r, err_nxt;
    logic phase_r, phase_nxt; // 0 wait, 1 check
    logic clr_r, clr_nxt;
    logic fault_now, tlow_fault;
    pwr_state_e en_state;

    // low limit counts only with switch in cc mode or at enable rise
    always_comb begin
        tlow_fault = p.tlow && (p.const_current || p.enable_rise);
        fault_now = (|p.fault_in) || tlow_fault;
        en_state = p.enable ? PST_ACTIVE : PST_STANDBY;
    end

    // next-state logic for one port, all state local to the port
    always_comb begin
        state_nxt = state_r;
        beh_nxt = p.behavior;
        hit_nxt = hit_r;
        alert_nxt = alert_r;
        err_nxt = err_r;
        phase_nxt = phase_r;
        // charge held at zero while rationing is off, even in error
        clr_nxt = !p.limit_enable;
        case (state_r)
            PST_ERROR: begin
                if (p.status_read) begin
                    alert_nxt = 1'b0;
                end
                if (!p.latch_set) begin
                    if (!phase_r && p.retry_tick_wait) begin
                        phase_nxt = 1'b1;
                    end else if (phase_r && p.retry_tick_check) begin
                        phase_nxt = 1'b0;
                        if (!fault_now) begin
                            state_nxt = en_state;
                            err_nxt = 1'b0;
                            // keep alert if rationing still reports
                            alert_nxt = hit_r &&
                                (beh_r != BEH_IGNORE) &&
                                (beh_r != BEH_DISC_SLEEP);
                        end
                    end
                end else if (p.enable_fall || p.err_clear) begin
                    // single check; host repeats if fault remains
                    if (!fault_now) begin
                        state_nxt = en_state;
                        err_nxt = 1'b0;
                    end
                    if (p.enable_fall) begin
                        alert_nxt = 1'b0;
                    end
                end
            end
            default: begin
                if (fault_now && p.enable) begin
                    state_nxt = PST_ERROR;
                    err_nxt = 1'b1;
                    alert_nxt = 1'b1;
                    phase_nxt = 1'b0;
                end else begin
                    if (p.status_read) begin
                        alert_nxt = 1'b0;
                    end
                    if (p.enable_rise || p.enable_fall) begin
                        alert_nxt = 1'b0;
                    end
                    if (state_r != PST_SLEEP || !hit_r) begin
                        state_nxt = en_state;
                    end
                    // threshold crossing, only in active
                    if (!hit_r && p.threshold_hit && p.limit_enable &&
                        state_r == PST_ACTIVE) begin
                        hit_nxt = 1'b1;
                        case (p.behavior)
                            BEH_REPORT: alert_nxt = 1'b1;
                            BEH_REPORT_DISC: alert_nxt = 1'b1;
                            BEH_DISC_SLEEP: state_nxt = PST_SLEEP;
                            default: ;
                        endcase
                    end else if (hit_r && p.behavior != beh_r) begin
                        case (p.behavior)
                            BEH_IGNORE: begin
                                alert_nxt = 1'b0;
                                state_nxt = en_state;
                            end
                            BEH_REPORT: begin
                                alert_nxt = 1'b1;
                                state_nxt = en_state;
                            end
                            BEH_REPORT_DISC: begin
                                alert_nxt = 1'b1;
                                state_nxt = en_state;
                            end
                            default: begin
                                alert_nxt = 1'b0;
                                state_nxt = PST_SLEEP;
                            end
                        endcase
                    end
                    if (p.limit_clear) begin
                        clr_nxt = 1'b1;
                        if (hit_r) begin
                            hit_nxt = 1'b0;
                            if (beh_r != BEH_DISC_SLEEP) begin
                                alert_nxt = 1'b0;
                            end
                            state_nxt = en_state;
                        end
                    end
                    if (!p.limit_enable) begin
                        clr_nxt = 1'b1;
                        if (hit_r) begin
                            hit_nxt = 1'b0;
                            alert_nxt = 1'b0;
                            state_nxt = en_state;
                        end
                    end
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= PST_STANDBY;
            beh_r <= BEH_RESET;
            hit_r <= 1'b0;
            alert_r <= 1'b0;
            err_r <= 1'b0;
            phase_r <= 1'b0;
            clr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            beh_r <= beh_nxt;
            hit_r <= hit_nxt;
            alert_r <= alert_nxt;
            err_r <= err_nxt;
            phase_r <= phase_nxt;
            clr_r <= clr_nxt;
        end
    end

    // switch stays open while a disconnecting limit is latched
    assign p.switch_on = (state_r == PST_ACTIVE) &&
        !(hit_r && (beh_r == BEH_REPORT_DISC || beh_r == BEH_DISC_SLEEP));
    assign p.alert = alert_r;
    assign p.charge_limit_hit_flag_flag = hit_r;
    assign p.err_flag = err_r;
    assign p.charge_clear = clr_r;
    assign p.accum_run = (state_r == PST_ACTIVE) && p.limit_enable;
    assign p.state = state_r;
endmodule
`default_nettype wire

// File: shared/charge_limit_hit_flag_pkg.sv
`default_nettype none
package charge_limit_hit_flag_pkg;
    // charge limit behaviour encodings
    localparam logic [1:0] BEH_REPORT = 2'h0;
    localparam logic [1:0] BEH_REPORT_DISC = 2'h1;
    localparam logic [1:0] BEH_DISC_SLEEP = 2'h2;
    localparam logic [1:0] BEH_IGNORE = 2'h3;
    localparam logic [1:0] BEH_RESET = BEH_REPORT_DISC;
    // register offsets of the interrupt status registers
    localparam logic [7:0] ADDR_IRQ_STATUS_A = 8'h03;
    localparam logic [7:0] ADDR_IRQ_STATUS_B = 8'h04;
    // status bit positions
    localparam int ST_ERR = 0;
    localparam int ST_CHARGE_LIMIT_HIT_FLAG = 1;
    localparam int ST_FAULT = 2;
    // accumulator and charge widths
    localparam int CHARGE_W = 16;
    localparam logic [15:0] CHARGE_ZERO = 16'h0000;
    // timing at 40 MHz
    localparam int CLK_MHZ = 40;
    localparam int RETRY_WAIT_US = 20000;
    localparam int RETRY_CHECK_US = 3000;
    localparam int RETRY_WAIT_CYC = RETRY_WAIT_US * CLK_MHZ;
    localparam int RETRY_CHECK_CYC = RETRY_CHECK_US * CLK_MHZ;
    localparam int CNT_W = 24;
    // port power states
    typedef enum logic [1:0] {
        PST_ACTIVE,
        PST_STANDBY,
        PST_SLEEP,
        PST_ERROR
    } pwr_state_e;
endpackage
`default_nettype wire

// File: shared/port_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface port_ctl_if;
    import charge_limit_hit_flag_pkg::*;
    logic enable;
    logic enable_rise;
    logic enable_fall;
    logic [1:0] behavior;
    logic limit_enable;
    logic limit_clear;
    logic threshold_hit;
    logic [5:0] fault_in;
    logic tlow;
    logic const_current;
    logic latch_set;
    logic err_clear;
    logic status_read;
    logic retry_tick_wait;
    logic retry_tick_check;
    logic switch_on;
    logic alert;
    logic charge_limit_hit_flag_flag;
    logic err_flag;
    logic charge_clear;
    logic accum_run;
    pwr_state_e state;
    modport top (output enable, enable_rise, enable_fall, behavior,
        limit_enable, limit_clear, threshold_hit, fault_in, tlow,
        const_current, latch_set, err_clear, status_read,
        retry_tick_wait, retry_tick_check,
        input switch_on, alert, charge_limit_hit_flag_flag, err_flag, charge_clear,
        accum_run, state);
    modport port (input enable, enable_rise, enable_fall, behavior,
        limit_enable, limit_clear, threshold_hit, fault_in, tlow,
        const_current, latch_set, err_clear, status_read,
        retry_tick_wait, retry_tick_check,
        output switch_on, alert, charge_limit_hit_flag_flag, err_flag, charge_clear,
        accum_run, state);
endinterface
`default_nettype wire

// File: logic/charge_limit_hit_flag_fault_state_control.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - report to disconnect opens switch, alert kept
// - to sleep: release alert, open, sleep
// - change to ignore releases rationing alert
// - leaving disconnecting behaviours re-samples enables
// - disconnect to sleep: release alert, sleep
// - leaving sleep for report asserts alert
// - sleep to disconnect: enable state, switch open
// - enable cleared early zeroes charge
// - enable cleared late clears flag, alert, rechecks
// - clear command zeroes charge, accumulation continues
// - late clear runs behaviour reset sequence
// - reset clears charge, flag, alert, rechecks
// - rationing acts only in active state
// - latch select picks mode, auto default
// - listed conditions are faults
// - low thermal limit conditional fault
// - low thermal limit otherwise not fault
// - auto mode: error, wait, check, return
// - release alert only if nothing else asserts
// - latched mode rechecks on host command
// - unread alert held until enable toggles
// - status read drops alert, error stays
module charge_limit_hit_flag_fault_state_control #(
    parameter int WAIT_CYC = charge_limit_hit_flag_pkg::RETRY_WAIT_CYC, // retry wait
    parameter int CHECK_CYC = charge_limit_hit_flag_pkg::RETRY_CHECK_CYC // retry check
) (
    input wire logic sys_clk, // 40 MHz clock
    input wire logic rstn, // sync reset, low
    input wire logic [1:0] port_power_enable, // port enables
    input wire logic [3:0] charge_limit_behavior, // 2 bits per port
    input wire logic [1:0] charge_limit_enable, // per port
    input wire logic [1:0] charge_limit_clear, // write-one pulse
    input wire logic [1:0] threshold_hit, // charge reached limit
    input wire logic [11:0] fault_in, // 6 fault sources per port
    input wire logic thermal_low_limit, // die above low limit
    input wire logic [1:0] const_current, // switch in cc mode
    input wire logic latch_set, // 1 latched, 0 auto
    input wire logic [1:0] err_clear, // host clears error bit
    input wire logic reg_rd, // register read strobe
    input wire logic [7:0] reg_addr, // register address
    output logic [7:0] reg_rdata, // read data
    output logic [1:0] switch_on, // power switch closed
    output logic [1:0] alert_n_oe, // low drives alert low
    output logic [1:0] charge_limit_hit_flag, // rationing status
    output logic [1:0] charge_clear, // zero accumulators
    output logic [1:0] accum_run, // accumulation allowed
    output logic [3:0] power_state // 2 bits per port
);
    import charge_limit_hit_flag_pkg::*;

    logic [1:0] en_d_r, en_d_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic tick_w_r, tick_w_nxt, tick_c_r, tick_c_nxt;
    logic [7:0] rdata_nxt;
    logic [1:0] rd_hit;
    logic [7:0] stat [2];
    logic [1:0] sw_w, al_w, fl_w, cc_w, ar_w, er_w;
    logic [3:0] ps_w;

    // read decode; status reads drop the per-port alert
    always_comb begin
        rd_hit = 2'h0;
        rdata_nxt = reg_rdata;
        if (reg_rd && reg_addr == ADDR_IRQ_STATUS_A) begin
            rd_hit = 2'h1;
            rdata_nxt = stat[0];
        end else if (reg_rd && reg_addr == ADDR_IRQ_STATUS_B) begin
            rd_hit = 2'h2;
            rdata_nxt = stat[1];
        end else if (reg_rd) begin
            rdata_nxt = 8'h00;
        end
    end

    // free-running retry timer shared by both ports
    always_comb begin
        en_d_nxt = port_power_enable;
        tick_w_nxt = 1'b0;
        tick_c_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(WAIT_CYC - 1)) begin
            tick_w_nxt = 1'b1;
        end
        if (cnt_r == CNT_W'(WAIT_CYC + CHECK_CYC - 1)) begin
            tick_c_nxt = 1'b1;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            en_d_r <= 2'h0;
            cnt_r <= '0;
            tick_w_r <= 1'b0;
            tick_c_r <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            en_d_r <= en_d_nxt;
            cnt_r <= cnt_nxt;
            tick_w_r <= tick_w_nxt;
            tick_c_r <= tick_c_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // one instance per port; retry timer, latch select and low limit are shared
    for (genvar i = 0; i < 2; i++) begin : g_port
        port_ctl_if pif ();
        assign pif.enable = port_power_enable[i];
        assign pif.enable_rise = port_power_enable[i] && !en_d_r[i];
        assign pif.enable_fall = !port_power_enable[i] && en_d_r[i];
        assign pif.behavior = charge_limit_behavior[2*i +: 2];
        assign pif.limit_enable = charge_limit_enable[i];
        assign pif.limit_clear = charge_limit_clear[i];
        assign pif.threshold_hit = threshold_hit[i];
        assign pif.fault_in = fault_in[6*i +: 6];
        assign pif.tlow = thermal_low_limit;
        assign pif.const_current = const_current[i];
        assign pif.latch_set = latch_set;
        assign pif.err_clear = err_clear[i];
        assign pif.status_read = rd_hit[i];
        assign pif.retry_tick_wait = tick_w_r;
        assign pif.retry_tick_check = tick_c_r;
        assign sw_w[i] = pif.switch_on;
        assign al_w[i] = pif.alert;
        assign fl_w[i] = pif.charge_limit_hit_flag_flag;
        assign er_w[i] = pif.err_flag;
        assign cc_w[i] = pif.charge_clear;
        assign ar_w[i] = pif.accum_run;
        assign ps_w[2*i +: 2] = pif.state;
        always_comb begin
            stat[i] = 8'h00;
            stat[i][ST_ERR] = er_w[i];
            stat[i][ST_CHARGE_LIMIT_HIT_FLAG] = fl_w[i];
            stat[i][ST_FAULT] = |fault_in[6*i +: 6];
        end
        port_charge_limit_hit_flag_fault u_port (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .p(pif.port)
        );
    end

    // outputs registered once more so they come from flops
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            switch_on <= 2'h0;
            alert_n_oe <= 2'h3;
            charge_limit_hit_flag <= 2'h0;
            charge_clear <= 2'h0;
            accum_run <= 2'h0;
            power_state <= {PST_STANDBY, PST_STANDBY};
        end else begin
            switch_on <= sw_w;
            alert_n_oe <= ~al_w;
            charge_limit_hit_flag <= fl_w;
            charge_clear <= cc_w;
            accum_run <= ar_w;
            power_state <= ps_w;
        end
    end
endmodule
`default_nettype wire

// File: dv/charge_limit_hit_flag_fault_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module charge_limit_hit_flag_fault_checker #(
    parameter int WAIT_CYC = 20, // retry wait
    parameter int CHECK_CYC = 5 // retry check
) (
    input wire logic sys_clk, // clock
    input wire logic rstn, // sync reset, low
    input wire logic [1:0] port_power_enable, // enables
    input wire logic [3:0] charge_limit_behavior, // behaviours
    input wire logic [1:0] charge_limit_enable, // rationing on
    input wire logic [1:0] charge_limit_clear, // clear pulse
    input wire logic [11:0] fault_in, // fault sources
    input wire logic latch_set, // latched mode
    input wire logic [1:0] err_clear, // error clear
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_rdata, // read data
    input wire logic [1:0] switch_on, // switches
    input wire logic [1:0] alert_n_oe, // alert drive
    input wire logic [1:0] charge_limit_hit_flag, // flags
    input wire logic [1:0] charge_clear, // zero pulse
    input wire logic [1:0] accum_run, // accumulate
    input wire logic [3:0] power_state // states
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // port 0 is watched; port 1 shares the same logic
    chk_fault_error: assert property (
        port_power_enable[0] && |fault_in[5:0] && power_state[1:0] == 2'h0
        |-> ##2 power_state[1:0] == 2'h3 && !alert_n_oe[0])
        else $error("fault did not force error");
    chk_latched_hold: assert property (
        (latch_set && !err_clear[0] && port_power_enable[0])[*4]
        ##0 power_state[1:0] == 2'h3 |=> power_state[1:0] == 2'h3)
        else $error("latched error left without host command");
    chk_unmapped_read: assert property (
        reg_rd && reg_addr != 8'h03 && reg_addr != 8'h04
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_clear_pulse: assert property (
        $rose(charge_limit_clear[0]) |-> ##2 charge_clear[0])
        else $error("clear command did not zero charge");
    chk_en_off_clear: assert property (
        !charge_limit_enable[0] |-> ##2 charge_clear[0])
        else $error("disabled rationing kept charge");
    chk_accum_active: assert property (
        accum_run[0] |-> power_state[1:0] == 2'h0)
        else $error("accumulating outside active");
    chk_disc_switch: assert property (
        (charge_limit_hit_flag[0] && charge_limit_behavior[1:0] == 2'h1)[*4]
        |-> !switch_on[0])
        else $error("switch closed after disconnect");
    chk_sleep_entry: assert property (
        (charge_limit_hit_flag[0] && charge_limit_behavior[1:0] == 2'h2
        && power_state[1:0] != 2'h3)[*4]
        |-> power_state[1:0] == 2'h2 && alert_n_oe[0])
        else $error("sleep behaviour not applied");

    cover property (power_state[1:0] == 2'h3);
    cover property (charge_limit_hit_flag[0]);
    cover property (latch_set && err_clear[0]);
endmodule

bind charge_limit_hit_flag_fault_state_control charge_limit_hit_flag_fault_checker #(
    .WAIT_CYC(WAIT_CYC), .CHECK_CYC(CHECK_CYC)) chk (
    .sys_clk(sys_clk), .rstn(rstn), .port_power_enable(port_power_enable),
    .charge_limit_behavior(charge_limit_behavior),
    .charge_limit_enable(charge_limit_enable),
    .charge_limit_clear(charge_limit_clear), .fault_in(fault_in),
    .latch_set(latch_set), .err_clear(err_clear), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .switch_on(switch_on),
    .alert_n_oe(alert_n_oe), .charge_limit_hit_flag(charge_limit_hit_flag),
    .charge_clear(charge_clear), .accum_run(accum_run),
    .power_state(power_state));
`default_nettype wire

// File: dv/charge_meter.sv
`timescale 1ns/1ps
`default_nettype none
module charge_meter #(
    parameter int LIMIT = 60 // charge units to threshold
) (
    input wire logic sys_clk, // clock
    input wire logic rstn, // sync reset, low
    input wire logic [1:0] run, // accumulate enable
    input wire logic [1:0] zero, // clear accumulators
    output logic [1:0] hit // threshold reached
);
    int acc [2];
    // one-cycle threshold pulse, then parks past the limit until cleared;
    // a level here would re-trip while the clear is still in flight
    always @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!rstn || zero[i]) begin
                acc[i] <= 0;
            end else if (run[i] && acc[i] <= LIMIT) begin
                acc[i] <= acc[i] + 1;
            end
        end
    end
    assign hit = {acc[1] == LIMIT, acc[0] == LIMIT};
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import charge_limit_hit_flag_pkg::*;
    localparam int WAIT = 20;
    localparam int CHECK = 5;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] en = 2'h3;
    logic [3:0] beh = 4'h0;
    logic [1:0] lim_en = 2'h0;
    logic [1:0] lim_clr = 2'h0;
    logic [11:0] fault = 12'h000;
    logic tlow = 1'b0;
    logic [1:0] cc = 2'h0;
    logic latch = 1'b0;
    logic [1:0] errc = 2'h0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] rdata, d;
    logic [1:0] sw, alert_n, flag, zero, run, hit;
    logic [3:0] st;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;

    charge_limit_hit_flag_fault_state_control #(.WAIT_CYC(WAIT), .CHECK_CYC(CHECK)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .port_power_enable(en),
        .charge_limit_behavior(beh), .charge_limit_enable(lim_en),
        .charge_limit_clear(lim_clr), .threshold_hit(hit), .fault_in(fault),
        .thermal_low_limit(tlow), .const_current(cc), .latch_set(latch),
        .err_clear(errc), .reg_rd(rd), .reg_addr(addr), .reg_rdata(rdata),
        .switch_on(sw), .alert_n_oe(alert_n), .charge_limit_hit_flag(flag),
        .charge_clear(zero), .accum_run(run), .power_state(st));
    charge_meter #(.LIMIT(60)) meter (.sys_clk(sys_clk), .rstn(rstn),
        .run(run), .zero(zero), .hit(hit));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end

    // inputs always move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_reg(input logic [7:0] a);
        rd = 1'b1;
        addr = a;
        tick(1);
        rd = 1'b0;
        d = rdata;
    endtask

    task automatic wait_st(input logic [1:0] v, input int lim);
        for (int i = 0; i < lim && st[1:0] !== v; i++) tick(1);
        check("port0 state", st[1:0], v);
    endtask

    // one fault pattern on port 0, then auto recovery
    task automatic flt(input logic [5:0] f, input logic t, c);
        fault[5:0] = f;
        tlow = t;
        cc[0] = c;
        tick(3);
        check("fault state", st[1:0], PST_ERROR);
        check("fault alert", alert_n[0], 1'b0);
        check("other port", st[3:2], PST_ACTIVE);
        fault[5:0] = 6'h00;
        tlow = 1'b0;
        cc[0] = 1'b0;
        wait_st(PST_ACTIVE, WAIT + CHECK + 10);
        tick(2);
        check("recover alert", alert_n[0], 1'b1);
    endtask

    task automatic step(input logic [1:0] b, input logic a, s,
            input logic [1:0] p);
        beh[1:0] = b;
        tick(3);
        check("alert", alert_n[0], a);
        check("switch", sw[0], s);
        check("state", st[1:0], p);
    endtask

    task automatic hit_wait;
        for (int i = 0; i < 200 && flag[0] !== 1'b1; i++) tick(1);
        tick(2);
        check("hit flag", flag[0], 1'b1);
    endtask

    initial begin
        tick(4);
        check("reset switch", sw, 2'h0);
        check("reset alert", alert_n, 2'h3);
        check("reset state", st, 4'h5);
        check("reset rdata", rdata, 8'h00);
        rstn = 1'b1;
        wait_st(PST_ACTIVE, 10);
        tlow = 1'b1;
        tick(5);
        check("low limit only", st[1:0], PST_ACTIVE);
        tlow = 1'b0;
        for (int i = 0; i < 6; i++) flt(6'h01 << i, 1'b0, 1'b0);
        flt(6'h00, 1'b1, 1'b1);
        // latched handling
        latch = 1'b1;
        fault[0] = 1'b1;
        tick(3);
        rd_reg(ADDR_IRQ_STATUS_A);
        check("err bit", d[ST_ERR], 1'b1);
        tick(3);
        check("alert read", alert_n[0], 1'b1);
        tick(WAIT + CHECK + 10);
        check("latched", st[1:0], PST_ERROR);
        errc[0] = 1'b1;
        tick(1);
        errc[0] = 1'b0;
        tick(3);
        check("retry refused", st[1:0], PST_ERROR);
        fault[0] = 1'b0;
        errc[0] = 1'b1;
        tick(1);
        errc[0] = 1'b0;
        wait_st(PST_ACTIVE, 10);
        fault[0] = 1'b1;
        tick(3);
        fault[0] = 1'b0;
        tick(WAIT);
        check("unread alert", alert_n[0], 1'b0);
        en[0] = 1'b0;
        tick(1);
        en[0] = 1'b1;
        wait_st(PST_ACTIVE, 10);
        tick(2);
        check("toggle alert", alert_n[0], 1'b1);
        latch = 1'b0;
        rd_reg(8'h10);
        check("unmapped", d, 8'h00);
        tick(1);
        rd_reg(ADDR_IRQ_STATUS_B);
        check("port1 status", d, 8'h00);
        // rationing on port 0
        check("zero idle", zero[0], 1'b1);
        lim_en[0] = 1'b1;
        hit_wait();
        step(BEH_REPORT, 1'b0, 1'b1, PST_ACTIVE);
        step(BEH_REPORT_DISC, 1'b0, 1'b0, PST_ACTIVE);
        step(BEH_IGNORE, 1'b1, 1'b1, PST_ACTIVE);
        step(BEH_REPORT, 1'b0, 1'b1, PST_ACTIVE);
        check("port1 switch", sw[1], 1'b1);
        lim_clr[0] = 1'b1;
        tick(1);
        lim_clr[0] = 1'b0;
        tick(3);
        check("clr flag", flag[0], 1'b0);
        check("clr alert", alert_n[0], 1'b1);
        hit_wait();
        step(BEH_DISC_SLEEP, 1'b1, 1'b0, PST_SLEEP);
        step(BEH_REPORT_DISC, 1'b0, 1'b0, PST_ACTIVE);
        step(BEH_DISC_SLEEP, 1'b1, 1'b0, PST_SLEEP);
        step(BEH_IGNORE, 1'b1, 1'b1, PST_ACTIVE);
        lim_en[0] = 1'b0;
        tick(3);
        check("off flag", flag[0], 1'b0);
        check("off zero", zero[0], 1'b1);
        check("off alert", alert_n[0], 1'b1);
        results();
    end
endmodule
`default_nettype wire
